// ---- ddcsp_pkg.sv ----
// Shared constants and types of the serial data port
// Assumes one master clock domain; config writes come from the control interface
`default_nettype none
package ddcsp_pkg;
  localparam int CFG_ADDR_W = 5;
  localparam logic [4:0] SERIAL_PORT_CONFIG_ADDR = 5'h00;
  localparam int CFG_W = 16;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 2;
  localparam int MODE_BIT = 2;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int WORD_W = 16;
  localparam int FRAME_W = 4 * WORD_W;
  localparam logic [6:0] FRAME_BITS_MODE0 = 7'h40;
  localparam logic [6:0] FRAME_BITS_MODE1 = 7'h20;
  localparam int SEC_TAP = 2 * WORD_W - 1;
  localparam int IN_WORD_BITS = 16;
  localparam logic [3:0] IN_LAST = 4'hF;
  localparam int DAC_W = 12;
  localparam int DIV_CNT_W = 3;

  typedef struct packed {
    logic [WORD_W-1:0] chan_a_inphase;
    logic [WORD_W-1:0] chan_a_quadrature;
    logic [WORD_W-1:0] chan_b_inphase;
    logic [WORD_W-1:0] chan_b_quadrature;
  } ddcsp_iq_type;

  typedef struct packed {
    logic mode;
    logic [DIV_W-1:0] div;
  } ddcsp_cfg_type;

  typedef enum logic [1:0] {
    OUT_IDLE = 2'b00,
    OUT_SYNC = 2'b01,
    OUT_SHIFT = 2'b10
  } ddcsp_out_state_type;

  typedef enum logic [0:0] {
    IN_IDLE = 1'b0,
    IN_SHIFT = 1'b1
  } ddcsp_in_state_type;
endpackage
`default_nettype wire

// ---- ddcsp_clkdiv.sv ----
// Serial clock divider: master clock over two to the divide exponent
// Assumes div may change at any time; a count at or past the new last value wraps to zero, a lower one runs on
`default_nettype none
module ddcsp_clkdiv
  import ddcsp_pkg::*;
#(
  parameter int CNT_W = DIV_CNT_W
) (
  input wire logic clk, // Master clock
  input wire logic rst, // Async reset, high
  input wire logic [DIV_W-1:0] div, // Divide exponent
  output logic tick, // Leading edge at this clk edge
  output logic serial_out_clock // Divided clock out
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] last;
  logic [CNT_W-1:0] half;
  logic sclk_q;

  always_comb begin
    last = CNT_W'((1 << div) - 1);
    half = (div == '0) ? CNT_W'(1) : CNT_W'(1 << (div - 1));
    cnt_d = (cnt_q >= last) ? '0 : cnt_q + CNT_W'(1);
    tick = (cnt_d == '0);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // High for the first half of each period, so the rise marks the leading edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= (cnt_d < half);
    end
  end

  // Exponent zero passes the master clock itself; no flop can make it
  assign serial_out_clock = (div == '0) ? clk : sclk_q;

  logic [CNT_W-1:0] gap_q;
  logic [DIV_W-1:0] div_prev_q;
  logic div_same_q;
  // Own copy of the last exponent keeps the period check free of tool inference
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q <= '0;
      div_prev_q <= '0;
      div_same_q <= 1'b0;
    end else begin
      gap_q <= tick ? '0 : gap_q + CNT_W'(1);
      div_prev_q <= div;
      div_same_q <= tick ? 1'b1 : (div_same_q && (div == div_prev_q));
    end
  end

  AST_DIV_PERIOD: assert property (@(posedge clk) disable iff (rst)
    (tick && div_same_q && div == $past(div)) |-> gap_q == last)
    else $error("serial clock period differs from two to the exponent");
endmodule
`default_nettype wire

// ---- ddcsp_port.sv ----
// Serial data port top: output framer, input word receiver, config register
// Assumes filter results arrive as a one-cycle strobe, and serial_in_data and
// in_frame_pulse are synchronous to the master clock
// Behaviour
// - The serial clock is the master clock divided by two to an exponent of 0 to 3.
// - In mode zero all four filter words go out on the primary line.
// - In mode one channel A words use the primary line and channel B the secondary.
// - A new filter result starts a frame after any frame in progress, with a frame pulse one serial period long; a newer result replaces one still waiting.
// - After the pulse the bits go out MSB first, one per leading serial clock edge.
// - A frame holds 64 bits in mode zero and 32 bits per line in mode one.
// - The 16 leading edges after the input pulse carry one word, MSB first.
// - The low 12 bits of each input word go to the auxiliary DAC unsigned.
// - Input and output streams run independently, both on the same serial clock.
// - Config register zero holds exponent and mode and is written by the control port.
`default_nettype none
module ddcsp_port
  import ddcsp_pkg::*;
#(
  parameter int DAC_BITS = DAC_W
) (
  input wire logic clk, // Master clock
  input wire logic rst, // Async reset, high
  input wire logic cfg_wr, // Register write strobe
  input wire logic [CFG_ADDR_W-1:0] cfg_addr, // Register address
  input wire logic [CFG_W-1:0] cfg_wdata, // Write data
  output logic [CFG_W-1:0] cfg_rdata, // Read data of cfg_addr
  input wire logic filt_valid, // New filter results
  input wire ddcsp_iq_type filt_data, // Four filter words
  input wire logic in_frame_pulse, // Input word start
  input wire logic serial_in_data, // Input data line
  output logic serial_out_clock, // Serial clock out
  output logic out_frame_pulse, // Output frame pulse
  output logic primary_data_line, // Output line 0
  output logic secondary_data_line, // Output line 1
  output logic [DAC_BITS-1:0] dac_data, // Auxiliary DAC word
  output logic dac_strobe // DAC word update
);
  ddcsp_cfg_type cfg_q;
  logic tick;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= ddcsp_cfg_type'(CFG_RESET[MODE_BIT:0]);
    end else if (cfg_wr && cfg_addr == SERIAL_PORT_CONFIG_ADDR) begin
      cfg_q.div <= cfg_wdata[DIV_LSB +: DIV_W];
      cfg_q.mode <= cfg_wdata[MODE_BIT];
    end
  end

  always_comb begin
    cfg_rdata = '0;
    if (cfg_addr == SERIAL_PORT_CONFIG_ADDR) begin
      cfg_rdata[DIV_LSB +: DIV_W] = cfg_q.div;
      cfg_rdata[MODE_BIT] = cfg_q.mode;
    end
  end

  ddcsp_clkdiv #(
    .CNT_W(DIV_CNT_W)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .div(cfg_q.div),
    .tick(tick),
    .serial_out_clock(serial_out_clock)
  );

  // Output framer
  ddcsp_out_state_type out_state_q;
  ddcsp_iq_type hold_q;
  logic pend_q;
  logic frame_mode_q;
  logic [FRAME_W-1:0] out_sr_q;
  logic [6:0] bit_cnt_q;
  logic fs_q;
  logic prim_q;
  logic sec_q;
  logic [6:0] frame_bit_count;
  logic start;
  logic frame_end;

  assign frame_bit_count = frame_mode_q ? FRAME_BITS_MODE1 : FRAME_BITS_MODE0;
  assign frame_end = (out_state_q == OUT_SHIFT) && (bit_cnt_q == frame_bit_count);
  assign start = tick && pend_q && (out_state_q == OUT_IDLE || frame_end);

  // A result landing while one waits replaces it; spacing is software's duty
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      hold_q <= '0;
    end else begin
      if (filt_valid) begin
        hold_q <= filt_data;
      end
      pend_q <= filt_valid || (pend_q && !start);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_state_q <= OUT_IDLE;
      out_sr_q <= '0;
      bit_cnt_q <= '0;
      fs_q <= 1'b0;
      prim_q <= 1'b0;
      sec_q <= 1'b0;
      frame_mode_q <= 1'b0;
    end else if (tick) begin
      if (start) begin
        out_state_q <= OUT_SYNC;
        out_sr_q <= hold_q;
        frame_mode_q <= cfg_q.mode;
        fs_q <= 1'b1;
        prim_q <= 1'b0;
        sec_q <= 1'b0;
        bit_cnt_q <= '0;
      end else begin
        case (out_state_q)
          OUT_SYNC, OUT_SHIFT: begin
            if (frame_end) begin
              out_state_q <= OUT_IDLE;
              prim_q <= 1'b0;
              sec_q <= 1'b0;
            end else begin
              out_state_q <= OUT_SHIFT;
              fs_q <= 1'b0;
              prim_q <= out_sr_q[FRAME_W-1];
              sec_q <= frame_mode_q ? out_sr_q[SEC_TAP] : 1'b0;
              out_sr_q <= {out_sr_q[FRAME_W-2:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 7'h01;
            end
          end
          default: begin
            out_state_q <= OUT_IDLE;
          end
        endcase
      end
    end
  end

  assign out_frame_pulse = fs_q;
  assign primary_data_line = prim_q;
  assign secondary_data_line = sec_q;

  // Input receiver, free of any tie to the output framer
  ddcsp_in_state_type in_state_q;
  logic [3:0] in_cnt_q;
  logic [IN_WORD_BITS-1:0] in_sr_q;
  logic [DAC_BITS-1:0] dac_q;
  logic dac_stb_q;
  logic [IN_WORD_BITS-1:0] in_word;

  assign in_word = {in_sr_q[IN_WORD_BITS-2:0], serial_in_data};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_state_q <= IN_IDLE;
      in_cnt_q <= '0;
      in_sr_q <= '0;
    end else if (tick) begin
      case (in_state_q)
        IN_IDLE: begin
          if (in_frame_pulse) begin
            in_state_q <= IN_SHIFT;
            in_cnt_q <= '0;
          end
        end
        IN_SHIFT: begin
          in_sr_q <= in_word;
          in_cnt_q <= in_cnt_q + 4'h1;
          if (in_cnt_q == IN_LAST) begin
            in_state_q <= IN_IDLE;
          end
        end
        default: begin
          in_state_q <= IN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_q <= '0;
      dac_stb_q <= 1'b0;
    end else begin
      dac_stb_q <= 1'b0;
      if (tick && in_state_q == IN_SHIFT && in_cnt_q == IN_LAST) begin
        dac_q <= in_word[DAC_BITS-1:0];
        dac_stb_q <= 1'b1;
      end
    end
  end

  assign dac_data = dac_q;
  assign dac_strobe = dac_stb_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_FS_ONE_PERIOD: assert property ((fs_q && tick) |=> !fs_q || $past(start))
    else $error("frame pulse longer than one serial period");
  AST_FS_ON_RESULT: assert property ($rose(fs_q) |-> $past(pend_q) && $past(tick))
    else $error("frame pulse without pending result");
  AST_MSB_FIRST: assert property ($fell(fs_q) |-> prim_q == $past(out_sr_q[FRAME_W-1]))
    else $error("first bit is not the word MSB");
  AST_ORDER: assert property ($rose(fs_q) |-> out_sr_q == $past(hold_q))
    else $error("frame word order wrong");
  AST_MODE0_SEC_IDLE: assert property (!frame_mode_q |-> !sec_q)
    else $error("secondary line active in mode zero");
  AST_MODE1_SEC: assert property (($fell(fs_q) && frame_mode_q)
    |-> sec_q == $past(out_sr_q[SEC_TAP]))
    else $error("secondary line not carrying channel B");
  AST_FRAME_LEN: assert property ((out_state_q == OUT_SHIFT) |-> bit_cnt_q <= frame_bit_count)
    else $error("frame bit count exceeded");
  AST_FRAME_END: assert property ((tick && frame_end && !pend_q)
    |=> out_state_q == OUT_IDLE && !prim_q)
    else $error("frame did not end after its bit count");
  AST_IN16: assert property ($rose(dac_stb_q) |-> $past(in_cnt_q) == IN_LAST)
    else $error("input word not sixteen bits");
  AST_DAC_PULSE: assert property (dac_stb_q |=> !dac_stb_q)
    else $error("dac strobe longer than one cycle");
  AST_CFG_WRITE: assert property ((cfg_wr && cfg_addr == SERIAL_PORT_CONFIG_ADDR)
    |=> cfg_q.div == $past(cfg_wdata[DIV_LSB +: DIV_W]))
    else $error("config write not taken");

  COV_MODE0_FRAME: cover property (tick && frame_end && !frame_mode_q);
  COV_MODE1_FRAME: cover property (tick && frame_end && frame_mode_q);
  COV_BACK_TO_BACK: cover property (start && frame_end);
  COV_DAC_WORD: cover property (dac_stb_q);
endmodule
`default_nettype wire

// ---- ddcsp_dsp_model.sv ----
// Behavioural model of the DSP serial port on the far side of the data port
// Assumes serial_out_clock comes from the device; samples and drives on its falling edge
`default_nettype none
module ddcsp_dsp_model (
  input wire logic serial_out_clock, // Device serial clock
  input wire logic out_frame_pulse, // Output frame pulse
  input wire logic primary_data_line, // Output line 0
  input wire logic secondary_data_line, // Output line 1
  input wire logic [6:0] frame_bits, // Bits expected per line
  output logic in_frame_pulse, // Input word start
  output logic serial_in_data // Input data line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] rx_pri = 64'h0;
  logic [31:0] rx_sec = 32'h0;
  int frames = 0;
  int plen = 0;
  int cnt = 0;
  bit active = 0;
  bit in_pulse = 0;
  bit busy = 0;
  initial in_frame_pulse = 1'b0;
  initial serial_in_data = 1'b0;
  // Mid-period sampling avoids racing the leading-edge updates
  always @(negedge serial_out_clock) begin
    if (out_frame_pulse) begin
      plen = in_pulse ? plen + 1 : 1;
      in_pulse = 1;
      active = 1;
      cnt = 0;
    end else begin
      in_pulse = 0;
      if (active) begin
        rx_pri = {rx_pri[62:0], primary_data_line};
        rx_sec = {rx_sec[30:0], secondary_data_line};
        cnt++;
        if (cnt == int'(frame_bits)) begin
          active = 0;
          frames++;
        end
      end
    end
  end
  // Idle line toggles so a stale bit can never be mistaken for data
  always @(negedge serial_out_clock) begin
    if (!busy) serial_in_data <= ~serial_in_data;
  end
  task automatic send_word(input logic [15:0] w);
    busy = 1;
    @(negedge serial_out_clock);
    in_frame_pulse = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(negedge serial_out_clock);
      in_frame_pulse = 1'b0;
      serial_in_data = w[i];
    end
    // Release after the last bit is sampled, so a following word keeps its line
    @(posedge serial_out_clock);
    busy = 0;
  endtask
endmodule
`default_nettype wire

// ---- ddcsp_tb.sv ----
// Self-checking bench for the serial data port with a DSP port model
// Assumes a 125 MHz master clock and the register layout of the package
`default_nettype none
module tb;
  import ddcsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr = 1'b0;
  logic [CFG_ADDR_W-1:0] cfg_addr = '0;
  logic [CFG_W-1:0] cfg_wdata = '0;
  logic [CFG_W-1:0] cfg_rdata;
  logic filt_valid = 1'b0;
  ddcsp_iq_type filt_data = '0;
  logic in_frame_pulse, serial_in_data, serial_out_clock, out_frame_pulse;
  logic primary_data_line, secondary_data_line, dac_strobe;
  logic [DAC_W-1:0] dac_data;
  logic [6:0] frame_bit_count = FRAME_BITS_MODE0;
  int err_total = 0;
  int comparisons = 0;
  int edges = 0;
  always #4 clk = ~clk;
  always @(posedge serial_out_clock) edges++;
  ddcsp_port ddcsp_port_inst (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .filt_valid(filt_valid),
    .filt_data(filt_data), .in_frame_pulse(in_frame_pulse), .serial_in_data(serial_in_data),
    .serial_out_clock(serial_out_clock), .out_frame_pulse(out_frame_pulse),
    .primary_data_line(primary_data_line), .secondary_data_line(secondary_data_line),
    .dac_data(dac_data), .dac_strobe(dac_strobe));
  ddcsp_dsp_model ddcsp_dsp_model_inst (.serial_out_clock(serial_out_clock),
    .out_frame_pulse(out_frame_pulse), .primary_data_line(primary_data_line),
    .secondary_data_line(secondary_data_line), .frame_bits(frame_bit_count),
    .in_frame_pulse(in_frame_pulse), .serial_in_data(serial_in_data));
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg_write(input logic [4:0] a, input logic [15:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    tick();
    cfg_wr = 1'b0;
    tick();
  endtask
  task automatic send_result(input logic [63:0] d);
    filt_valid = 1'b1;
    filt_data = d;
    tick();
    filt_valid = 1'b0;
    tick();
  endtask
  task automatic wait_frames(input int n);
    int i;
    for (i = 0; i < 3000 && ddcsp_dsp_model_inst.frames < n; i++) tick();
    chk(ddcsp_dsp_model_inst.frames, n);
  endtask
  task automatic wait_strobe();
    int i;
    for (i = 0; i < 400 && dac_strobe !== 1'b1; i++) tick();
    chk(dac_strobe, 1);
  endtask
  task automatic t_regs();
    chk(cfg_rdata, CFG_RESET);
    cfg_write(5'h00, 16'hFFFF);
    chk(cfg_rdata, 16'h0007);
    cfg_write(5'h01, 16'h0002);
    chk(cfg_rdata, 16'h0000);
    cfg_addr = 5'h00;
    #1;
    chk(cfg_rdata, 16'h0007);
  endtask
  task automatic t_div();
    for (int d = 0; d < 4; d++) begin
      cfg_write(5'h00, 16'(d));
      repeat (16) tick();
      edges = 0;
      repeat (64) tick();
      chk(edges, 64 >> d);
    end
  endtask
  task automatic t_frame(input logic m, input logic [1:0] d, input logic [63:0] v);
    int f0;
    f0 = ddcsp_dsp_model_inst.frames;
    frame_bit_count = m ? FRAME_BITS_MODE1 : FRAME_BITS_MODE0;
    cfg_write(5'h00, {13'h0000, m, d});
    send_result(v);
    wait_frames(f0 + 1);
    chk(ddcsp_dsp_model_inst.plen, 1);
    if (m) begin
      chk(ddcsp_dsp_model_inst.rx_pri[31:0], v[63:32]);
      chk(ddcsp_dsp_model_inst.rx_sec, v[31:0]);
    end else begin
      chk(ddcsp_dsp_model_inst.rx_pri, v);
      chk(ddcsp_dsp_model_inst.rx_sec, 0);
    end
  endtask
  task automatic t_b2b();
    int f0;
    f0 = ddcsp_dsp_model_inst.frames;
    frame_bit_count = FRAME_BITS_MODE1;
    cfg_write(5'h00, 16'h0004);
    send_result(64'h8001_7FFE_C003_3FFC);
    // Results 32 serial periods apart: the second waits for the first 33-period mode-one frame to end
    repeat (30) tick();
    send_result(64'h1234_5678_9ABC_DEF0);
    wait_frames(f0 + 1);
    chk(ddcsp_dsp_model_inst.rx_pri[31:0], 32'h8001_7FFE);
    wait_frames(f0 + 2);
    chk(ddcsp_dsp_model_inst.rx_pri[31:0], 32'h1234_5678);
    chk(ddcsp_dsp_model_inst.rx_sec, 32'h9ABC_DEF0);
  endtask
  task automatic t_input();
    int f0;
    f0 = ddcsp_dsp_model_inst.frames;
    frame_bit_count = FRAME_BITS_MODE0;
    cfg_write(5'h00, 16'h0002);
    fork
      begin
        ddcsp_dsp_model_inst.send_word(16'hA5C3);
        ddcsp_dsp_model_inst.send_word(16'h5FFF);
      end
    join_none
    send_result(64'hF0F0_0F0F_AAAA_5555);
    wait_strobe();
    chk(dac_data, 12'h5C3);
    tick();
    wait_strobe();
    chk(dac_data, 12'hFFF);
    wait_frames(f0 + 1);
    chk(ddcsp_dsp_model_inst.rx_pri, 64'hF0F0_0F0F_AAAA_5555);
  endtask
  task automatic finish_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_regs();
    t_div();
    t_frame(1'b0, 2'h0, 64'h8123_4567_89AB_CDEF);
    t_frame(1'b1, 2'h1, 64'hFEDC_BA98_7654_3210);
    t_frame(1'b0, 2'h3, 64'h0001_8000_FFFF_0000);
    t_b2b();
    t_input();
    finish_test();
  end
endmodule
`default_nettype wire
